/* File: rtl/shc_rx_checker.sv */
// shc_rx_checker.sv: receive end, aligns multiblocks and checks parity.
// assumes blocks already block-aligned; fec correction is left to later logic.
`timescale 1ns/1ps
`include "shc_consts.svh"

module shc_rx_checker
    import shc_pkg::*;
#(
    parameter int FEC_CONFIRM = `SHC_FEC_CONFIRM
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // link
    shc_link_if.rx           link,
    // configuration
    input  wire logic [1:0]  sync_header_stream_select,
    // user block output
    output logic             blk_out_valid,
    output logic [63:0]      blk_out_data,
    // status
    output logic             mb_locked,
    output logic             chk_valid,
    output logic             chk_err,
    output shc_par_t         syndrome,
    output logic             extended_multiblock_end_flag,
    output logic             sh_err
);

    // ----------------------------------------------------------------
    // stream field extraction
    // ----------------------------------------------------------------
    function automatic shc_par_t shc_extract(input logic [1:0] mode,
                                            input shc_word_t w);
        shc_par_t p;
        p = '0;
        if (mode == `SHC_MODE_FEC) begin
            for (int n = 0; n < 22; n++) begin
                p[25-n] = w[n];
            end
            for (int n = 23; n < 27; n++) begin
                p[26-n] = w[n];
            end
        end else begin
            for (int g = 0; g < 4; g++) begin
                for (int k = 0; k < 3; k++) begin
                    p[11-3*g-k] = w[4*g+k];
                end
            end
        end
        return p;
    endfunction

    // self-synchronous descrambler: the state shifts in received bits
    function automatic logic [121:0] shc_descramble(input logic [57:0] st_in,
                                                   input logic [63:0] d);
        logic [57:0] st;
        logic [63:0] p;
        st = st_in;
        p  = '0;
        for (int i = 63; i >= 0; i--) begin
            p[i] = d[i] ^ st[`SHC_SCR_TAP_A] ^ st[`SHC_SCR_TAP_B];
            st   = {st[56:0], d[i]};
        end
        return {st, p};
    endfunction

    logic        is_fec;
    logic        sbit;
    logic [31:0] hist;
    logic [31:0] next_hist;
    shc_word_t   word;
    logic        pilot;
    logic [4:0]  blk_idx;
    logic [3:0]  cnt;
    logic        prev_ok;
    shc_par_t    acc;
    shc_par_t    next_acc;
    shc_par_t    prev_par;
    logic [57:0] dsc_state;
    logic [63:0] next_plain;
    logic [57:0] next_dsc_state;
    shc_par_t    next_syn;
    logic        aligned;
    shc_align_t  state;
    logic        at_end;

    assign is_fec    = sync_header_stream_select == `SHC_MODE_FEC;
    assign sbit      = link.sync_hdr == `SHC_SH_ONE;
    assign aligned   = state != SHC_HUNT;
    assign next_syn  = shc_extract(sync_header_stream_select, word) ^ prev_par;
    assign next_hist = {hist[30:0], sbit};
    assign pilot     = next_hist[4:0] == `SHC_PILOT;
    assign at_end    = blk_idx == `SHC_MB_LAST;
    assign next_acc  = shc_par_upd(acc, link.payload, sync_header_stream_select);

    always_comb begin
        word = '0;
        for (int n = 0; n < 32; n++) begin
            word[n] = next_hist[31-n];
        end
    end

    assign {next_dsc_state, next_plain} = shc_descramble(dsc_state, link.payload);

    // ----------------------------------------------------------------
    // history, descrambler and user output
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // ones, so no false pilot straddles the reset
            hist          <= '1;
            dsc_state     <= {58{1'b1}};
            blk_out_valid <= 1'b0;
            blk_out_data  <= '0;
            sh_err        <= 1'b0;
        end else begin
            blk_out_valid <= link.blk_valid;
            sh_err        <= link.blk_valid && link.sync_hdr != `SHC_SH_ONE
                             && link.sync_hdr != `SHC_SH_ZERO;
            if (link.blk_valid) begin
                hist         <= next_hist;
                dsc_state    <= next_dsc_state;
                blk_out_data <= next_plain;
            end
        end
    end

    // ----------------------------------------------------------------
    // multiblock alignment
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= SHC_HUNT;
            blk_idx   <= 5'h00;
            cnt       <= 4'h0;
            mb_locked <= 1'b0;
        end else begin
            mb_locked <= state == SHC_LOCK;
            if (link.blk_valid) begin
                blk_idx <= blk_idx + 5'h01;
                unique case (state)
                    SHC_HUNT: begin
                        if (pilot) begin
                            blk_idx <= 5'h00;
                            cnt     <= 4'h1;
                            state   <= is_fec ? SHC_CHECK : SHC_LOCK;
                        end
                    end
                    SHC_CHECK: begin
                        if (at_end) begin
                            cnt <= cnt + 4'h1;
                            if (!pilot) begin
                                state <= SHC_HUNT;
                            end else if (int'(cnt) + 1 >= FEC_CONFIRM) begin
                                state <= SHC_LOCK;
                            end
                        end
                    end
                    SHC_LOCK: begin
                        if (at_end && !pilot) begin
                            state <= SHC_HUNT;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // local parity and comparison one multiblock later
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc       <= '0;
            prev_par  <= '0;
            prev_ok   <= 1'b0;
            chk_valid <= 1'b0;
            chk_err   <= 1'b0;
            syndrome  <= '0;
            extended_multiblock_end_flag <= 1'b0;
        end else begin
            chk_valid <= 1'b0;
            if (link.blk_valid) begin
                if (!aligned || at_end) begin
                    acc <= '0;
                end else begin
                    acc <= next_acc;
                end
                if (!aligned) begin
                    prev_ok <= 1'b0;
                end
                if (aligned && at_end) begin
                    prev_par  <= next_acc;
                    prev_ok   <= pilot;
                    chk_valid <= prev_ok && pilot;
                    if (prev_ok && pilot) begin
                        syndrome <= next_syn;
                        chk_err  <= next_syn != '0;
                    end
                    extended_multiblock_end_flag <= word[`SHC_EXTENDED_MULTIBLOCK_END_FLAG_POS];
                end
            end
        end
    end

endmodule

/* File: rtl/shc_consts.svh */
// shc_consts.svh: numeric constants of the sync header stream encoder and checker.
// assumes inclusion by bare name from the package and both link ends.
`ifndef SHC_CONSTS_SVH
`define SHC_CONSTS_SVH

// ----------------------------------------------------------------
// sync header stream select codes
// ----------------------------------------------------------------
`define SHC_MODE_CRC 2'h0
`define SHC_MODE_FEC 2'h2

// ----------------------------------------------------------------
// parity generators (low terms, top term implied by width)
// ----------------------------------------------------------------
`define SHC_CRC_W    12
`define SHC_FEC_W    26
`define SHC_CRC_POLY 26'h000030f
`define SHC_FEC_POLY 26'h0220211

// ----------------------------------------------------------------
// block, multiblock and stream layout
// ----------------------------------------------------------------
`define SHC_BLK_W      64
`define SHC_MB_LAST    5'h1f
`define SHC_EXTENDED_MULTIBLOCK_END_FLAG_POS  22
`define SHC_PILOT      5'h01
`define SHC_SH_ONE     2'h1
`define SHC_SH_ZERO    2'h2
`define SHC_SCR_TAP_A  38
`define SHC_SCR_TAP_B  57
`define SHC_FEC_CONFIRM 4

`endif

/* File: rtl/shc_pkg.sv */
// shc_pkg.sv: types and the shared parity update for both link ends.
// assumes shc_consts.svh on the include path.
`include "shc_consts.svh"

package shc_pkg;

    typedef logic [25:0] shc_par_t;
    typedef logic [31:0] shc_word_t;

    typedef enum logic [2:0] {
        SHC_HUNT  = 3'b001,
        SHC_CHECK = 3'b010,
        SHC_LOCK  = 3'b100
    } shc_align_t;

    // ----------------------------------------------------------------
    // bit-serial divide of one block, first sent bit is data[63]
    // ----------------------------------------------------------------
    function automatic shc_par_t shc_par_upd(input shc_par_t s_in,
                                             input logic [63:0] d,
                                             input logic [1:0] mode);
        shc_par_t s;
        shc_par_t poly;
        int       w;
        logic     fb;
        s    = s_in;
        poly = (mode == `SHC_MODE_FEC) ? `SHC_FEC_POLY : `SHC_CRC_POLY;
        w    = (mode == `SHC_MODE_FEC) ? `SHC_FEC_W : `SHC_CRC_W;
        for (int i = `SHC_BLK_W - 1; i >= 0; i--) begin
            fb = d[i] ^ s[w-1];
            s  = s << 1;
            if (w < `SHC_FEC_W) begin
                s[`SHC_FEC_W-1:`SHC_CRC_W] = '0;
            end
            if (fb) begin
                s = s ^ poly;
            end
        end
        return s;
    endfunction

endpackage

/* File: rtl/shc_link_if.sv */
// shc_link_if.sv: 66-bit block link between the stream encoder and its checker.
// assumes both ends run on one shared clock; one block per valid cycle.
`timescale 1ns/1ps

interface shc_link_if;
    logic        blk_valid;
    logic [1:0]  sync_hdr;
    logic [63:0] payload;

    modport tx (
        output blk_valid,
        output sync_hdr,
        output payload
    );

    modport rx (
        input  blk_valid,
        input  sync_hdr,
        input  payload
    );
endinterface

/* File: rtl/shc_tx_encoder.sv */
// shc_tx_encoder.sv: transmit end, scrambles blocks and builds the sync header stream.
// assumes a sync reset before traffic and blocks offered by valid/ready on clk_sys.
`timescale 1ns/1ps
`include "shc_consts.svh"

module shc_tx_encoder
    import shc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // user block input
    input  wire logic        blk_in_valid,
    input  wire logic [63:0] blk_in_data,
    output logic             blk_in_ready,
    // configuration
    input  wire logic [1:0]  sync_header_stream_select,
    input  wire logic [4:0]  ext_mb_count,
    // status
    output logic             mb_end,
    output shc_par_t         last_parity,
    // link
    shc_link_if.tx           link
);

    // ----------------------------------------------------------------
    // stream mapping
    // ----------------------------------------------------------------
    // returns stream word indexed by stream position; extended_multiblock_end_flag left zero
    function automatic shc_word_t shc_build(input logic [1:0] mode,
                                           input shc_par_t par);
        shc_word_t w;
        w = '0;
        if (mode == `SHC_MODE_FEC) begin
            for (int n = 0; n < 22; n++) begin
                w[n] = par[25-n];
            end
            for (int n = 23; n < 27; n++) begin
                w[n] = par[26-n];
            end
        end else begin
            for (int g = 0; g < 4; g++) begin
                for (int k = 0; k < 3; k++) begin
                    w[4*g+k] = par[11-3*g-k];
                end
                w[4*g+3] = 1'b1;
            end
            w[19] = 1'b1;
            w[21] = 1'b1;
            w[23] = 1'b1;
            w[18:16] = 3'h0;
            w[20]    = 1'b0;
            w[26:24] = 3'h0;
        end
        w[31:27] = {1'b1, 4'h0};
        return w;
    endfunction

    // ----------------------------------------------------------------
    // self-synchronous scrambler, 1 + x^39 + x^58
    // ----------------------------------------------------------------
    function automatic logic [121:0] shc_scramble(input logic [57:0] st_in,
                                                 input logic [63:0] d);
        logic [57:0] st;
        logic [63:0] q;
        st = st_in;
        q  = '0;
        for (int i = 63; i >= 0; i--) begin
            q[i] = d[i] ^ st[`SHC_SCR_TAP_A] ^ st[`SHC_SCR_TAP_B];
            st   = {st[56:0], q[i]};
        end
        return {st, q};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic        take;
    logic        blk_last;
    logic [4:0]  blk_idx;
    logic [4:0]  mb_idx;
    logic [4:0]  mb_last_idx;
    logic        extended_multiblock_end_flag_cur;
    logic [1:0]  mode_q;
    logic [57:0] scr_state;
    logic [57:0] next_scr_state;
    logic [63:0] next_scrambled;
    shc_par_t    acc;
    shc_par_t    next_acc;
    shc_word_t   stream_q;
    logic        next_sbit;

    assign take     = blk_in_valid && blk_in_ready;
    assign blk_last = blk_idx == `SHC_MB_LAST;
    // an extended-multiblock count of zero behaves as one
    assign mb_last_idx = (ext_mb_count == 5'h00) ? 5'h00 : ext_mb_count - 5'h01;
    assign extended_multiblock_end_flag_cur   = mb_idx == mb_last_idx;

    assign {next_scr_state, next_scrambled} = shc_scramble(scr_state, blk_in_data);

    assign next_acc = shc_par_upd(acc, next_scrambled, mode_q);

    // stream bit n in block n
    assign next_sbit = (blk_idx == 5'(`SHC_EXTENDED_MULTIBLOCK_END_FLAG_POS)) ? extended_multiblock_end_flag_cur : stream_q[blk_idx];

    // ----------------------------------------------------------------
    // acceptance: no internal stall, ready once out of reset
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blk_in_ready <= 1'b0;
        end else begin
            blk_in_ready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // block and multiblock counters
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blk_idx <= 5'h00;
            mb_idx  <= 5'h00;
        end else if (take) begin
            blk_idx <= blk_idx + 5'h01;
            if (blk_last) begin
                mb_idx <= extended_multiblock_end_flag_cur ? 5'h00 : mb_idx + 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // scrambler state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scr_state <= {58{1'b1}};
        end else if (take) begin
            scr_state <= next_scr_state;
        end
    end

    // ----------------------------------------------------------------
    // mode: changes only at a multiblock border so one multiblock is
    // never divided by two generators
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // first multiblock after reset already uses the selected generator
            mode_q <= (sync_header_stream_select == `SHC_MODE_FEC) ?
                      `SHC_MODE_FEC : `SHC_MODE_CRC;
        end else if (take && blk_last) begin
            // other codes fall back to crc
            mode_q <= (sync_header_stream_select == `SHC_MODE_FEC) ?
                      `SHC_MODE_FEC : `SHC_MODE_CRC;
        end
    end

    // ----------------------------------------------------------------
    // parity accumulation and hand-off to the next multiblock
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc         <= '0;
            last_parity <= '0;
            stream_q    <= shc_build(`SHC_MODE_CRC, '0);
        end else if (take) begin
            if (blk_last) begin
                // read after 2048 bits, then clear
                acc         <= '0;
                last_parity <= next_acc;
                stream_q    <= shc_build(mode_q, next_acc);
            end else begin
                acc <= next_acc;
            end
        end
    end

    // ----------------------------------------------------------------
    // link output
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            link.blk_valid <= 1'b0;
            link.sync_hdr  <= `SHC_SH_ZERO;
            link.payload   <= '0;
            mb_end         <= 1'b0;
        end else begin
            link.blk_valid <= take;
            mb_end         <= take && blk_last;
            if (take) begin
                link.sync_hdr <= next_sbit ? `SHC_SH_ONE : `SHC_SH_ZERO;
                link.payload  <= next_scrambled;
            end
        end
    end

    // detection latency floors (46 blocks crc, 58 fec) follow from the
    // parity riding the next multiblock; nothing here shortens them.
    // latency set by one-multiblock delay

endmodule

/* File: test/shc_link_checker.sv */
// shc_link_checker.sv: assertions on the link between encoder and checker.
// assumes blocks flow from reset release with block 0 of a multiblock first.
`timescale 1ns/1ps
`include "shc_consts.svh"

module shc_link_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // link signals and mode
    input wire logic        blk_valid,
    input wire logic [1:0]  sync_hdr,
    input wire logic [63:0] payload,
    input wire logic [1:0]  sync_header_stream_select
);
    logic [4:0]  idx;
    logic [25:0] acc;
    logic [25:0] par;
    logic        have_par;
    logic        fec;
    logic        crc_b;
    logic        fec_b;
    int          k;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // reference parity, kept apart from the design's own update
    // ----------------------------------------------------------------
    function automatic logic [25:0] upd(input logic [25:0] s_in, input logic [63:0] d,
                                        input logic f);
        logic [25:0] s;
        logic        fb;
        s = s_in;
        for (int i = 63; i >= 0; i--) begin
            fb = d[i] ^ (f ? s[25] : s[11]);
            s = s << 1;
            if (!f) begin
                s[25:12] = '0;
            end
            if (fb) begin
                s = s ^ (f ? 26'h0220211 : 26'h000030f);
            end
        end
        return s;
    endfunction

    assign fec = (sync_header_stream_select == `SHC_MODE_FEC);
    assign k   = int'(idx);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idx <= 5'h00;
        end else if (blk_valid) begin
            idx <= idx + 5'h01;
        end
    end

    // first multiblock carries no parity worth checking
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc      <= '0;
            par      <= '0;
            have_par <= 1'b0;
        end else if (blk_valid && idx == 5'h1f) begin
            acc      <= '0;
            par      <= upd(acc, payload, fec);
            have_par <= 1'b1;
        end else if (blk_valid) begin
            acc <= upd(acc, payload, fec);
        end
    end

    always_comb begin
        crc_b = (k < 15) ? par[11 - 3 * (k / 4) - k % 4] : 1'b0;
        fec_b = (k < 22) ? par[25 - k] : ((k > 22 && k < 27) ? par[26 - k] : 1'b0);
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_one;
        sync_hdr == 2'h1;
    endsequence

    property p_hdr_legal;
        blk_valid |-> (sync_hdr == 2'h1 || sync_hdr == 2'h2);
    endproperty
    a_hdr_legal: assert property (p_hdr_legal) else $error("bad sync header");

    property p_pilot_zero;
        blk_valid && idx >= 5'h1b && idx <= 5'h1e |-> sync_hdr == 2'h2;
    endproperty
    a_pilot_zero: assert property (p_pilot_zero) else $error("pilot zero wrong");

    property p_pilot_one;
        blk_valid && idx == 5'h1f |-> s_one;
    endproperty
    a_pilot_one: assert property (p_pilot_one) else $error("pilot one wrong");

    property p_crc_par;
        blk_valid && have_par && !fec && k < 15 && k % 4 != 3
            |-> sync_hdr == (crc_b ? 2'h1 : 2'h2);
    endproperty
    a_crc_par: assert property (p_crc_par) else $error("crc bit wrong");

    property p_crc_fixed;
        blk_valid && !fec && ((k % 4 == 3 && k < 24) || k == 21) |-> s_one;
    endproperty
    a_crc_fixed: assert property (p_crc_fixed) else $error("fixed one wrong");

    property p_crc_cmd;
        blk_valid && !fec && k inside {16, 17, 18, 20, 24, 25, 26} |-> sync_hdr == 2'h2;
    endproperty
    a_crc_cmd: assert property (p_crc_cmd) else $error("command bit wrong");

    property p_fec_par;
        blk_valid && have_par && fec && k < 22 |-> sync_hdr == (fec_b ? 2'h1 : 2'h2);
    endproperty
    a_fec_par: assert property (p_fec_par) else $error("fec high bit wrong");

    property p_fec_low;
        blk_valid && have_par && fec && k > 22 && k < 27 |-> sync_hdr == (fec_b ? 2'h1 : 2'h2);
    endproperty
    a_fec_low: assert property (p_fec_low) else $error("fec low bit wrong");

    c_crc_mb: cover property (blk_valid && have_par && !fec && idx == 5'h1f);
    c_fec_mb: cover property (blk_valid && have_par && fec && idx == 5'h1f);
    c_gap: cover property (blk_valid ##1 !blk_valid);
endmodule

/* File: test/test_sync_header_crc_fec_encoder.sv */
// test_sync_header_crc_fec_encoder.sv: encoder facing a clean and a faulted checker.
// assumes design files and shc_link_checker compiled first.
`timescale 1ns/1ps
`include "shc_consts.svh"

module test_sync_header_crc_fec_encoder;
    import shc_pkg::*;

    localparam int NMB = 9;
    localparam int E   = 3;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        blk_in_valid = 1'b0;
    logic [63:0] blk_in_data = '0;
    logic [1:0]  sel = `SHC_MODE_CRC;
    logic        blk_in_ready;
    logic        blk_out_valid;
    logic [63:0] blk_out_data;
    logic        mb_locked;
    logic        chk_valid;
    logic        chk_err;
    logic        sh_err;
    logic        chk_valid_f;
    logic        chk_err_f;
    logic        sh_err_f;
    logic        mb_end;
    logic        eflag;
    shc_par_t    syndrome;
    shc_par_t    syndrome_f;
    logic        flip;
    logic        bad;
    logic        sh_seen;
    shc_word_t   word;
    logic [63:0] exp_q[$];
    int          num_errors = 0;
    int          n_checks = 0;
    int          idx = 0;
    int          mbn = 0;
    int          err2;
    int          nchk1;

    shc_link_if link();
    shc_link_if link_f();

    // faulted copy: one payload bit in mb 4, one illegal header in mb 7
    assign flip = (mbn == 4 && idx == 5);
    assign bad  = (mbn == 7 && idx == 3);
    assign link_f.blk_valid = link.blk_valid;
    assign link_f.payload   = link.payload ^ {63'h0, flip};
    assign link_f.sync_hdr  = link.sync_hdr | {2{bad}};

    shc_tx_encoder shc_tx_encoder_inst (.clk_sys(clk_sys), .rst(rst),
        .blk_in_valid(blk_in_valid), .blk_in_data(blk_in_data), .blk_in_ready(blk_in_ready),
        .sync_header_stream_select(sel), .ext_mb_count(5'(E)), .mb_end(mb_end), .last_parity(),
        .link(link));
    shc_rx_checker #(.FEC_CONFIRM(2)) shc_rx_checker_inst (.clk_sys(clk_sys), .rst(rst),
        .link(link), .sync_header_stream_select(sel), .blk_out_valid(blk_out_valid),
        .blk_out_data(blk_out_data), .mb_locked(mb_locked), .chk_valid(chk_valid),
        .chk_err(chk_err), .syndrome(syndrome), .extended_multiblock_end_flag(eflag),
        .sh_err(sh_err));
    shc_rx_checker #(.FEC_CONFIRM(2)) shc_rx_checker_inst_f (.clk_sys(clk_sys), .rst(rst),
        .link(link_f), .sync_header_stream_select(sel), .blk_out_valid(),
        .blk_out_data(), .mb_locked(), .chk_valid(chk_valid_f), .chk_err(chk_err_f),
        .syndrome(syndrome_f), .extended_multiblock_end_flag(), .sh_err(sh_err_f));
    shc_link_checker shc_link_checker_inst (.clk_sys(clk_sys), .rst(rst),
        .blk_valid(link.blk_valid), .sync_hdr(link.sync_hdr), .payload(link.payload),
        .sync_header_stream_select(sel));

    always #12.5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // valid and data held until ready is seen at an edge
    task automatic send_block(input logic [63:0] d);
        int n;
        n = 0;
        blk_in_valid <= 1'b1;
        blk_in_data  <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (blk_in_ready !== 1'b1 && n < 64);
        if (n >= 64) chk(64'h0, 64'h1);
    endtask

    task automatic run_mode(input logic [1:0] m);
        sel <= m;
        rst <= 1'b1;
        err2 = 0;
        nchk1 = 0;
        sh_seen = 1'b0;
        exp_q.delete();
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int b = 0; b < NMB * 32 + 8; b++) begin
            send_block(64'(b) * 64'h9e3779b97f4a7c15 ^ 64'(m));
        end
        blk_in_valid <= 1'b0;
        repeat (80) @(posedge clk_sys);
        chk(64'(err2), 64'h1);
        chk(64'(sh_seen), 64'h1);
        chk(64'(nchk1 >= 4), 64'h1);
        chk(64'(mb_locked), 64'h1);
        $display("test mode %0h done", m);
    endtask

    // ----------------------------------------------------------------
    // monitors and main sequence
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            idx <= 0;
            mbn <= 0;
        end else if (link.blk_valid === 1'b1) begin
            word[idx] = (link.sync_hdr == 2'h1);
            chk(64'(mb_end), 64'(idx == 31));
            if (idx == 31) begin
                chk(64'(word[31:27]), 64'h10);
                chk(64'(word[22]), 64'((mbn % E) == E - 1));
                if (sel == `SHC_MODE_CRC) begin
                    chk(64'(word & 32'h07bf8888), 64'h00a88888);
                end
                mbn <= mbn + 1;
            end
            idx <= (idx + 1) % 32;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst && blk_in_valid && blk_in_ready === 1'b1) exp_q.push_back(blk_in_data);
        if (!rst && blk_out_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(64'h1, 64'h0);
            else chk(blk_out_data, exp_q.pop_front());
        end
        if (!rst && chk_valid === 1'b1) begin
            nchk1++;
            chk(64'(chk_err), 64'h0);
            chk(64'(syndrome), 64'h0);
            chk(64'(eflag), 64'(((mbn - 1) % E) == E - 1));
        end
        if (!rst && sh_err === 1'b1) chk(64'h1, 64'h0);
        if (!rst && chk_valid_f === 1'b1 && chk_err_f === 1'b1 && mbn <= 6) begin
            err2++;
            chk(64'(syndrome_f != '0), 64'h1);
        end
        if (!rst && sh_err_f === 1'b1) sh_seen = 1'b1;
    end

    initial begin
        run_mode(`SHC_MODE_CRC);
        run_mode(`SHC_MODE_FEC);
        stop_test();
    end

    // two modes need well under 1000 cycles each
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule
